/* src/isr_pkg.sv */
// shared constants and types for the inductive sensor status readout
package isr_pkg;

	// register addresses
	localparam logic [7:0] ISR_ADDR_RPMAX = 8'h01; // maximum impedance setting
	localparam logic [7:0] ISR_ADDR_RPMIN = 8'h02; // minimum impedance setting
	localparam logic [7:0] ISR_ADDR_CFG   = 8'h04; // amplitude and response time
	localparam logic [7:0] ISR_ADDR_THI   = 8'h07; // comparator high threshold
	localparam logic [7:0] ISR_ADDR_TLO   = 8'h09; // comparator low threshold
	localparam logic [7:0] ISR_ADDR_INTM  = 8'h0a; // interrupt pin mode
	localparam logic [7:0] ISR_ADDR_PWR   = 8'h0b; // power configuration
	localparam logic [7:0] ISR_ADDR_STAT  = 8'h20; // converter status
	localparam logic [7:0] ISR_ADDR_PROX  = 8'h22; // proximity result
	localparam logic [7:0] ISR_ADDR_FCL   = 8'h23; // frequency count low byte
	localparam logic [7:0] ISR_ADDR_FCM   = 8'h24; // frequency count middle byte
	localparam logic [7:0] ISR_ADDR_FCH   = 8'h25; // frequency count high byte

	// reset values
	localparam logic [7:0] ISR_RST_RPMAX = 8'h00; // plain default
	localparam logic [7:0] ISR_RST_RPMIN = 8'h14; // invalid until host rewrites it
	localparam logic [7:0] ISR_RST_CFG   = 8'h1b;
	localparam logic [7:0] ISR_RST_THI   = 8'hff;
	localparam logic [7:0] ISR_RST_TLO   = 8'h00;
	localparam logic [7:0] ISR_RST_INTM  = 8'h00;
	localparam logic [7:0] ISR_RST_PWR   = 8'h00;

	// writable bit masks, reserved bits held at zero
	localparam logic [7:0] ISR_MASK_CFG  = 8'h1f;
	localparam logic [7:0] ISR_MASK_INTM = 8'h07;
	localparam logic [7:0] ISR_MASK_PWR  = 8'h01;

	// field positions
	localparam int ISR_POWER_MODE_SELECT_BIT = 0;
	localparam int ISR_STAT_OSC_BIT = 7;
	localparam int ISR_STAT_RDY_BIT = 6;
	localparam int ISR_STAT_WAKE_BIT = 5;
	localparam int ISR_STAT_CMP_BIT = 4;
	localparam int ISR_CFG_AMP_LSB  = 3;

	// interrupt pin modes
	localparam logic [2:0] ISR_INT_OFF  = 3'h0;
	localparam logic [2:0] ISR_INT_WAKE = 3'h1;
	localparam logic [2:0] ISR_INT_CMP  = 3'h2;
	localparam logic [2:0] ISR_INT_DRDY = 3'h4;

	// response time: code 2 means 192 periods, each code doubles; rate divider is a third of it
	localparam logic [2:0]  ISR_RESP_MIN_CODE = 3'h2;
	localparam int          ISR_RESP_MIN      = 192;
	localparam int          ISR_DIV_W         = 12;
	localparam logic [11:0] ISR_DIV_BASE      = 12'(ISR_RESP_MIN / 3);

	// frequency count width
	localparam int ISR_FC_W = 24;

	// register port request, one cycle per access
	typedef struct packed {
		logic       rd;    // read begins this cycle
		logic       wr;    // write this cycle
		logic [7:0] addr;  // register address
		logic [7:0] wdata; // write data
	} isr_req_t;

	// proximity sample from the analog front end
	typedef struct packed {
		logic       over_max;  // impedance above the maximum setting
		logic       under_min; // impedance below the minimum setting
		logic [7:0] value;     // raw proximity value
	} isr_prox_t;

	// converter power state
	typedef enum logic [1:0] {
		ISR_ST_STBY = 2'b01,
		ISR_ST_ACT  = 2'b10
	} isr_state_t;

endpackage

/* src/isr_readout.sv */
// power mode, status flags and conversion result readout of the inductive sensor converter
// Function
// R1: power bit selects standby or active, reserved zero
// R2: status bit 7 shows oscillator overloaded
// R3: status bit 6 low means fresh result
// R4: status bit 5 low when wake-up triggered
// R5: status bit 4 follows comparator with thresholds
// R6: proximity result readable at its address
// R7: 24-bit frequency count across three bytes
// R8: count loads only when proximity read begins
// R9: count holds until proximity read again
// R10: proximity clipped at impedance range limits
// R11: host writes only listed maximum impedance codes
// R12: host rewrites minimum impedance before active mode
// R13: rate is sensor frequency over response/3
// R14: interrupt pin mode selects pin function
// R15: high threshold register resets all ones
// R16: three count bytes captured in one cycle
`timescale 1ns/1ps
`default_nettype none
module isr_readout (
	input  wire logic               mclk_i,                  // system clock, 125 MHz
	input  wire logic               rst_n_i,                 // synchronous reset, active low
	input  wire isr_pkg::isr_req_t  req_i,                   // register port request
	output logic [7:0]              rdata_o,                 // read data
	output logic                    rvalid_o,                // read data valid pulse
	input  wire logic               sensor_osc_i,            // sensor oscillation pin
	input  wire logic               osc_fault_i,             // oscillator overload pin
	input  wire isr_pkg::isr_prox_t prox_i,                  // front end proximity sample
	output logic                    interrupt_pin_out_o,     // interrupt pin level
	output logic                    conv_active_o,           // conversions running
	output logic [7:0]              min_impedance_setting_o, // to front end
	output logic [7:0]              max_impedance_setting_o, // to front end
	output logic [1:0]              osc_amplitude_o          // to front end
);
	// configuration registers
	logic [7:0] rpmax_r, rpmax_nxt;
	logic [7:0] rpmin_r, rpmin_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic [7:0] thi_r, thi_nxt;
	logic [7:0] tlo_r, tlo_nxt;
	logic [7:0] intm_r, intm_nxt;
	logic [7:0] pwr_r, pwr_nxt;

	// conversion state
	isr_pkg::isr_state_t           state_r, state_nxt;    // power state
	logic [isr_pkg::ISR_DIV_W-1:0] scnt_r, scnt_nxt;      // sensor periods in this conversion
	logic [isr_pkg::ISR_FC_W-1:0]  mcnt_r, mcnt_nxt;      // clock cycles in this conversion
	logic [isr_pkg::ISR_FC_W-1:0]  fc_pend_r, fc_pend_nxt; // newest count, not yet visible
	logic [isr_pkg::ISR_FC_W-1:0]  fc_out_r, fc_out_nxt;  // count as the host sees it
	logic [7:0]                    prox_r, prox_nxt;      // newest proximity result
	logic                          rdy_n_r, rdy_n_nxt;    // data ready, active low
	logic                          cmp_r, cmp_nxt;        // comparator with hysteresis
	logic                          osc_d_r;               // delayed oscillation for edges
	logic [7:0]                    rdata_nxt;
	logic                          rvalid_nxt;
	logic                          intp_nxt;

	// helper terms
	logic [1:0]                    pin_s;     // synchronised {oscillation, fault}
	logic                          osc_edge;  // rising sensor edge
	logic                          fault_s;   // oscillator overloaded
	logic                          conv_done; // conversion completes this cycle
	logic                          prox_rd;   // read of the proximity result begins
	logic                          wake_bit;  // status bit 5
	logic [2:0]                    resp_code; // response time code
	logic [2:0]                    resp_sh;   // doublings above the shortest
	logic [isr_pkg::ISR_DIV_W-1:0] div;       // sensor periods per conversion
	logic [7:0]                    stat;      // status byte

	// both pins come from outside the clock domain
	isr_sync #(
		.W(2)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({sensor_osc_i, osc_fault_i}),
		.q_o     (pin_s)
	);

	assign fault_s  = pin_s[0];
	assign osc_edge = pin_s[1] & ~osc_d_r;
	assign prox_rd  = req_i.rd && (req_i.addr == isr_pkg::ISR_ADDR_PROX);

	// next values for all registers except osc_d_r, conv_active_o and the front end outputs
	always_comb begin
		rpmax_nxt  = rpmax_r;
		rpmin_nxt  = rpmin_r;
		cfg_nxt    = cfg_r;
		thi_nxt    = thi_r;
		tlo_nxt    = tlo_r;
		intm_nxt   = intm_r;
		pwr_nxt    = pwr_r;
		// writes to read-only addresses are dropped
		if (req_i.wr) begin
			case (req_i.addr)
				isr_pkg::ISR_ADDR_RPMAX: rpmax_nxt = req_i.wdata; // see R11
				isr_pkg::ISR_ADDR_RPMIN: rpmin_nxt = req_i.wdata; // see R12
				isr_pkg::ISR_ADDR_CFG:   cfg_nxt   = req_i.wdata & isr_pkg::ISR_MASK_CFG;
				isr_pkg::ISR_ADDR_THI:   thi_nxt   = req_i.wdata; // see R15
				isr_pkg::ISR_ADDR_TLO:   tlo_nxt   = req_i.wdata;
				isr_pkg::ISR_ADDR_INTM:  intm_nxt  = req_i.wdata & isr_pkg::ISR_MASK_INTM;
				isr_pkg::ISR_ADDR_PWR:   pwr_nxt   = req_i.wdata & isr_pkg::ISR_MASK_PWR; // see R1
				default: begin
				end
			endcase
		end

		// power state follows the mode bit
		case (state_r)
			isr_pkg::ISR_ST_STBY: state_nxt = pwr_r[isr_pkg::ISR_POWER_MODE_SELECT_BIT] ? isr_pkg::ISR_ST_ACT
				: isr_pkg::ISR_ST_STBY; // see R1
			isr_pkg::ISR_ST_ACT:  state_nxt = pwr_r[isr_pkg::ISR_POWER_MODE_SELECT_BIT] ? isr_pkg::ISR_ST_ACT
				: isr_pkg::ISR_ST_STBY;
			default:              state_nxt = isr_pkg::ISR_ST_STBY;
		endcase

		// conversion length: reserved short codes fall back to the shortest time
		resp_code = cfg_r[2:0];
		resp_sh   = (resp_code < isr_pkg::ISR_RESP_MIN_CODE) ? 3'h0 : resp_code - isr_pkg::ISR_RESP_MIN_CODE;
		div       = isr_pkg::ISR_DIV_BASE << resp_sh; // see R13

		// counters run only while active and oscillating
		conv_done = 1'b0;
		scnt_nxt  = scnt_r;
		mcnt_nxt  = mcnt_r;
		if (state_r != isr_pkg::ISR_ST_ACT || fault_s) begin
			scnt_nxt = '0;
			mcnt_nxt = '0;
		end else begin
			// saturate rather than wrap on a very slow sensor
			if (mcnt_r != {isr_pkg::ISR_FC_W{1'b1}})
				mcnt_nxt = mcnt_r + 1'b1;
			if (osc_edge) begin
				if (scnt_r >= div - 1'b1) begin
					conv_done = 1'b1; // see R13
					scnt_nxt  = '0;
					mcnt_nxt  = '0;
				end else begin
					scnt_nxt = scnt_r + 1'b1;
				end
			end
		end

		// new count waits in pending storage; the proximity result updates directly
		fc_pend_nxt = conv_done ? mcnt_r : fc_pend_r;
		prox_nxt    = prox_r;
		if (conv_done) begin
			if (prox_i.over_max)
				prox_nxt = 8'hff; // see R10
			else if (prox_i.under_min)
				prox_nxt = 8'h00; // see R10
			else
				prox_nxt = prox_i.value;
		end

		// visible count changes only as a proximity read begins, all bytes at once
		fc_out_nxt = prox_rd ? fc_pend_r : fc_out_r; // see R8, see R9, see R16

		// fresh result wins over the clearing read in the same cycle
		if (conv_done)
			rdy_n_nxt = 1'b0; // see R3
		else if (prox_rd)
			rdy_n_nxt = 1'b1;
		else
			rdy_n_nxt = rdy_n_r;

		// comparator hysteresis; low threshold wins on a misprogrammed pair
		if (prox_r < tlo_r)
			cmp_nxt = 1'b1; // see R5
		else if (prox_r > thi_r)
			cmp_nxt = 1'b0; // see R5
		else
			cmp_nxt = cmp_r;

		// wake-up bit reads one whenever the wake mode is off
		wake_bit = ~((intm_r[2:0] == isr_pkg::ISR_INT_WAKE) && (prox_r > thi_r)); // see R4
		stat     = {fault_s, rdy_n_r, wake_bit, cmp_r, 4'h0}; // see R2

		// interrupt pin, idle high
		case (intm_r[2:0])
			isr_pkg::ISR_INT_OFF:  intp_nxt = 1'b1; // see R14
			isr_pkg::ISR_INT_WAKE: intp_nxt = wake_bit;
			isr_pkg::ISR_INT_CMP:  intp_nxt = cmp_r;
			isr_pkg::ISR_INT_DRDY: intp_nxt = rdy_n_r;
			default:               intp_nxt = 1'b1;
		endcase

		// read mux, unmapped addresses read zero
		rvalid_nxt = req_i.rd;
		rdata_nxt  = 8'h00;
		if (req_i.rd) begin
			case (req_i.addr)
				isr_pkg::ISR_ADDR_RPMAX: rdata_nxt = rpmax_r;
				isr_pkg::ISR_ADDR_RPMIN: rdata_nxt = rpmin_r;
				isr_pkg::ISR_ADDR_CFG:   rdata_nxt = cfg_r;
				isr_pkg::ISR_ADDR_THI:   rdata_nxt = thi_r;
				isr_pkg::ISR_ADDR_TLO:   rdata_nxt = tlo_r;
				isr_pkg::ISR_ADDR_INTM:  rdata_nxt = intm_r;
				isr_pkg::ISR_ADDR_PWR:   rdata_nxt = pwr_r;
				isr_pkg::ISR_ADDR_STAT:  rdata_nxt = stat;            // see R2
				isr_pkg::ISR_ADDR_PROX:  rdata_nxt = prox_r;          // see R6
				isr_pkg::ISR_ADDR_FCL:   rdata_nxt = fc_out_r[7:0];   // see R7
				isr_pkg::ISR_ADDR_FCM:   rdata_nxt = fc_out_r[15:8];  // see R7
				isr_pkg::ISR_ADDR_FCH:   rdata_nxt = fc_out_r[23:16]; // see R7
				default:                 rdata_nxt = 8'h00;
			endcase
		end
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rpmax_r   <= isr_pkg::ISR_RST_RPMAX;
			rpmin_r   <= isr_pkg::ISR_RST_RPMIN;
			cfg_r     <= isr_pkg::ISR_RST_CFG;
			thi_r     <= isr_pkg::ISR_RST_THI; // see R15
			tlo_r     <= isr_pkg::ISR_RST_TLO;
			intm_r    <= isr_pkg::ISR_RST_INTM;
			pwr_r     <= isr_pkg::ISR_RST_PWR; // see R1
			state_r   <= isr_pkg::ISR_ST_STBY;
			scnt_r    <= '0;
			mcnt_r    <= '0;
			fc_pend_r <= '0;
			fc_out_r  <= '0;
			prox_r    <= 8'h00;
			rdy_n_r   <= 1'b1;
			cmp_r     <= 1'b1;
			osc_d_r   <= 1'b0;
			rdata_o   <= 8'h00;
			rvalid_o  <= 1'b0;
			interrupt_pin_out_o     <= 1'b1;
			conv_active_o           <= 1'b0;
			min_impedance_setting_o <= isr_pkg::ISR_RST_RPMIN;
			max_impedance_setting_o <= isr_pkg::ISR_RST_RPMAX;
			osc_amplitude_o         <= isr_pkg::ISR_RST_CFG[4:3];
		end else begin
			rpmax_r   <= rpmax_nxt;
			rpmin_r   <= rpmin_nxt;
			cfg_r     <= cfg_nxt;
			thi_r     <= thi_nxt;
			tlo_r     <= tlo_nxt;
			intm_r    <= intm_nxt;
			pwr_r     <= pwr_nxt;
			state_r   <= state_nxt;
			scnt_r    <= scnt_nxt;
			mcnt_r    <= mcnt_nxt;
			fc_pend_r <= fc_pend_nxt;
			fc_out_r  <= fc_out_nxt;
			prox_r    <= prox_nxt;
			rdy_n_r   <= rdy_n_nxt;
			cmp_r     <= cmp_nxt;
			osc_d_r   <= pin_s[1];
			rdata_o   <= rdata_nxt;
			rvalid_o  <= rvalid_nxt;
			interrupt_pin_out_o     <= intp_nxt;
			conv_active_o           <= (state_nxt == isr_pkg::ISR_ST_ACT);
			min_impedance_setting_o <= rpmin_nxt;
			max_impedance_setting_o <= rpmax_nxt;
			osc_amplitude_o         <= cfg_nxt[isr_pkg::ISR_CFG_AMP_LSB +: 2];
		end
	end

	// checks on the design's own behaviour
	a_pwr_reserved: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R1
		pwr_r[7:1] == 7'h00)
		else $error("power register reserved bits not zero");

	a_stby_noconv: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R1
		!pwr_r[0] ##1 !pwr_r[0] |-> !conv_done)
		else $error("conversion completed in standby");

	a_osc_status: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R2
		req_i.rd && req_i.addr == isr_pkg::ISR_ADDR_STAT |=> rdata_o[7] == $past(fault_s) && rdata_o[3:0] == 4'h0)
		else $error("status oscillator bit wrong");

	a_ready_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R3
		conv_done |=> !rdy_n_r)
		else $error("data ready not flagged after conversion");

	a_ready_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R3
		prox_rd && !conv_done |=> rdy_n_r)
		else $error("data ready not released by proximity read");

	a_wake_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R4
		intm_r[2:0] != isr_pkg::ISR_INT_WAKE |-> wake_bit)
		else $error("wake-up bit low while wake disabled");

	a_cmp_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R5
		prox_r < tlo_r |=> cmp_r)
		else $error("comparator not set below low threshold");

	a_cmp_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R5
		prox_r > thi_r && prox_r >= tlo_r |=> !cmp_r)
		else $error("comparator not cleared above high threshold");

	a_fc_capture: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R8
		prox_rd |=> fc_out_r == $past(fc_pend_r))
		else $error("frequency count not loaded on proximity read");

	a_fc_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R9
		!prox_rd |=> $stable(fc_out_r))
		else $error("frequency count changed without proximity read");

	a_clip_max: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R10
		conv_done && prox_i.over_max |=> prox_r == 8'hff)
		else $error("proximity not clipped at upper limit");

	a_conv_len: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R13
		conv_done |-> scnt_r == div - 1'b1)
		else $error("conversion length differs from response time over three");

	a_intp_drdy: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see R14
		intm_r[2:0] == isr_pkg::ISR_INT_DRDY |=> interrupt_pin_out_o == $past(rdy_n_r))
		else $error("interrupt pin not following data ready");
endmodule
`default_nettype wire

/* src/isr_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module isr_sync #(
	parameter int W = 1 // number of bits
) (
	input  wire logic         mclk_i,  // system clock
	input  wire logic         rst_n_i, // synchronous reset, active low
	input  wire logic [W-1:0] d_i,     // asynchronous input
	output logic      [W-1:0] q_o      // synchronised output
);
	logic [W-1:0] meta_r; // first stage, read only by the second
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// next values: plain shift
	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end

	// two stages
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_o    <= q_nxt;
		end
	end
endmodule
`default_nettype wire

/* verification/isr_readout_bench.sv */
// self-checking bench for the sensor status readout block
`timescale 1ns/1ps
`default_nettype none
module isr_readout_bench;
	logic               mclk_i      = 1'b0;         // system clock
	logic               rst_n_i     = 1'b0;         // reset, active low
	isr_pkg::isr_req_t  req_i       = '0;           // register requests
	isr_pkg::isr_prox_t prox_i      = '0;           // front end sample
	logic               osc_fault_i = 1'b0;         // oscillator fault pin
	logic               sensor_osc;                 // sensing pin
	logic [7:0]         rdata_o;                    // read data
	logic               rvalid_o;                   // read strobe
	logic               intp;                       // interrupt pin
	logic               act;                        // conversions running
	logic [7:0]         rmin;                       // min impedance to front end
	logic [7:0]         rmax;                       // max impedance to front end
	logic [1:0]         amp;                        // amplitude to front end
	int                 errors      = 0;            // mismatches
	int                 check_count = 0;            // comparisons made
	logic [31:0]        seed        = 32'hd04cff93; // random state
	logic [7:0]         rd_v;                       // last read value
	logic [7:0]         v;                          // expected proximity
	logic [23:0]        fc;                         // count read back
	logic               e_cmp       = 1'b1;         // expected comparator flag
	logic [2:0]         code;                       // response time code of this round
	logic [2:0]         modes [5]   = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3}; // pin modes tried

	// 125 MHz system clock
	always #4 mclk_i = ~mclk_i;

	isr_readout dut_u (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.sensor_osc_i(sensor_osc), .osc_fault_i(osc_fault_i), .prox_i(prox_i), .interrupt_pin_out_o(intp),
		.conv_active_o(act), .min_impedance_setting_o(rmin), .max_impedance_setting_o(rmax),
		.osc_amplitude_o(amp));

	// tank rings only while converting and not overloaded
	isr_sensor_model osc_u (.run_i(act & ~osc_fault_i), .osc_o(sensor_osc));

	// galois shift register for repeatable random values
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction

	// clipped proximity value, top limit wins
	function automatic logic [7:0] exp_prox(input isr_pkg::isr_prox_t p);
		if (p.over_max) return 8'hff;
		if (p.under_min) return 8'h00;
		return p.value;
	endfunction

	// clock cycles counted over one conversion: response/3 sensor periods of 125 ns at 8 ns
	function automatic int exp_cycles(input logic [2:0] c);
		int sh;
		sh = (c < isr_pkg::ISR_RESP_MIN_CODE) ? 0 : int'(c) - int'(isr_pkg::ISR_RESP_MIN_CODE);
		return ((isr_pkg::ISR_RESP_MIN << sh) / 3) * 125 / 8 - 1;
	endfunction

	// verdict and end of run
	task automatic complete_run();
		if (errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// byte comparison
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	// single pin or flag comparison
	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// count window; jitter of the synchroniser allows a few cycles
	task automatic check_range(input logic [23:0] got, input int lo, input int hi);
		check_count++;
		if ((got >= 24'(lo) && got <= 24'(hi)) !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// one-cycle read, data taken with the strobe one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i) #1;
		req_i.rd = 1'b1;
		req_i.addr = a;
		@(posedge mclk_i) #1;
		req_i.rd = 1'b0;
		check1(rvalid_o, 1'b1);
		d = rdata_o;
	endtask

	// one-cycle write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i) #1;
		req_i.wr = 1'b1;
		req_i.addr = a;
		req_i.wdata = d;
		@(posedge mclk_i) #1;
		req_i.wr = 1'b0;
	endtask

	// read and compare
	task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check8(d, exp);
	endtask

	// poll status until a fresh result waits; bounded so a dead converter is caught
	task automatic wait_rdy();
		int n = 0;
		do begin
			rd(isr_pkg::ISR_ADDR_STAT, rd_v);
			n++;
		end while (rd_v[6] !== 1'b0 && n < 1500);
		if (n >= 1500) begin
			errors++;
			$display("wrong value at %0t: no fresh result", $time);
		end
	endtask

	// watchdog, about three times the expected run length
	initial begin
		#400000;
		errors++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		rdck(isr_pkg::ISR_ADDR_PWR, 8'h00);
		rdck(isr_pkg::ISR_ADDR_THI, 8'hff);
		rdck(isr_pkg::ISR_ADDR_STAT, 8'h70);
		rdck(8'h30, 8'h00);
		check8(rmin, isr_pkg::ISR_RST_RPMIN);
		// host setup with listed impedance codes only
		wr(isr_pkg::ISR_ADDR_RPMAX, 8'h12);
		wr(isr_pkg::ISR_ADDR_RPMIN, 8'h3b);
		wr(isr_pkg::ISR_ADDR_CFG, 8'hea);   // reserved bits set, shortest response
		rdck(isr_pkg::ISR_ADDR_CFG, 8'h0a);
		check8({6'h00, amp}, 8'h01);
		check8(rmax, 8'h12);
		check8(rmin, 8'h3b);
		wr(isr_pkg::ISR_ADDR_THI, 8'hc0);
		wr(isr_pkg::ISR_ADDR_TLO, 8'h40);
		wr(isr_pkg::ISR_ADDR_INTM, 8'h01);
		// random samples with forced clipping corners first
		for (int i = 0; i < 4; i++) begin
			wr(isr_pkg::ISR_ADDR_PWR, 8'h00);
			// clear a result left from the last round, else the poll below passes at once
			rd(isr_pkg::ISR_ADDR_PROX, rd_v);
			rd(isr_pkg::ISR_ADDR_STAT, rd_v);
			check1(rd_v[6], 1'b1);
			// reserved short code and a longer response time among the rounds
			code = (i == 2) ? 3'h0 : (i == 3) ? 3'h3 : 3'h2;
			wr(isr_pkg::ISR_ADDR_CFG, {5'h01, code});
			seed = lfsr(seed);
			prox_i.value = seed[7:0];
			prox_i.over_max = (i == 0);
			prox_i.under_min = (i == 1) | (seed[8] & seed[9]);
			v = exp_prox(prox_i);
			if (v < 8'h40) begin
				e_cmp = 1'b1; // below low threshold
			end else if (v > 8'hc0) begin
				e_cmp = 1'b0; // above high threshold
			end
			wr(isr_pkg::ISR_ADDR_PWR, 8'hff);
			rdck(isr_pkg::ISR_ADDR_PWR, 8'h01);
			check1(act, 1'b1);
			wait_rdy();
			rdck(isr_pkg::ISR_ADDR_PROX, v);
			wait_rdy();
			rdck(isr_pkg::ISR_ADDR_PROX, v);
			rd(isr_pkg::ISR_ADDR_FCL, fc[7:0]);
			rd(isr_pkg::ISR_ADDR_FCM, fc[15:8]);
			rd(isr_pkg::ISR_ADDR_FCH, fc[23:16]);
			check_range(fc, exp_cycles(code) - 4, exp_cycles(code) + 6);
			rdck(isr_pkg::ISR_ADDR_STAT, {2'b01, ~(v > 8'hc0), e_cmp, 4'h0});
			// a new result arrives but the count must not move without a proximity read
			wait_rdy();
			rdck(isr_pkg::ISR_ADDR_FCL, fc[7:0]);
			rdck(isr_pkg::ISR_ADDR_FCM, fc[15:8]);
			rdck(isr_pkg::ISR_ADDR_FCH, fc[23:16]);
		end
		// pin modes in standby so the flags stand still
		wr(isr_pkg::ISR_ADDR_PWR, 8'h00);
		wr(isr_pkg::ISR_ADDR_INTM, {5'h00, modes[0]});
		repeat (4) @(posedge mclk_i);
		check1(intp, 1'b0);
		rd(isr_pkg::ISR_ADDR_PROX, rd_v);
		repeat (4) @(posedge mclk_i);
		check1(intp, 1'b1);
		for (int k = 1; k < 5; k++) begin
			wr(isr_pkg::ISR_ADDR_INTM, {5'h00, modes[k]});
			repeat (4) @(posedge mclk_i);
			check1(intp, (modes[k] == 3'h1) ? ~(v > 8'hc0) : (modes[k] == 3'h2) ? e_cmp : 1'b1);
		end
		// oscillator overload shows in the top status bit
		wr(isr_pkg::ISR_ADDR_PWR, 8'h01);
		osc_fault_i = 1'b1;
		repeat (6) @(posedge mclk_i);
		rd(isr_pkg::ISR_ADDR_STAT, rd_v);
		check1(rd_v[7], 1'b1);
		osc_fault_i = 1'b0;
		repeat (6) @(posedge mclk_i);
		rd(isr_pkg::ISR_ADDR_STAT, rd_v);
		check1(rd_v[7], 1'b0);
		check8({rd_v[3:0], 4'h0}, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire

/* verification/isr_sensor_model.sv */
// sensor tank oscillator model that drives the converter's sensing pin
`timescale 1ns/1ps
`default_nettype none
module isr_sensor_model #(
	parameter real HALF_NS = 62.5 // half period of the tank, 125 ns full period
) (
	input  wire logic run_i, // converter active and oscillator healthy
	output logic      osc_o  // oscillation seen at the sensing pin
);
	// the tank only rings while the converter drives it, so the pin rests low otherwise
	// phase is free against the system clock, which exercises the edge synchroniser
	initial begin
		osc_o = 1'b0;
		forever begin
			#(HALF_NS);
			if (run_i) begin
				osc_o = ~osc_o; // ringing
			end else begin
				osc_o = 1'b0; // stopped tank holds low
			end
		end
	end
endmodule
`default_nettype wire
